// >>> pkg/ppp_pkg.sv
package ppp_pkg;
   // action codes selected by action_code_hi/lo on a load_clock pulse
   localparam logic [1:0] ACT_LOAD_ADDR = 2'b00;
   localparam logic [1:0] ACT_LOAD_DATA = 2'b01;
   localparam logic [1:0] ACT_LOAD_CMD = 2'b10;
   localparam logic [1:0] ACT_IDLE = 2'b11;
   // command bytes
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
   localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
   localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
   localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
   localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
   localparam logic [7:0] CMD_READ_SIG = 8'h08;
   localparam logic [7:0] CMD_READ_FUSE_LOCK = 8'h04;
   localparam logic [7:0] CMD_READ_FLASH = 8'h02;
   localparam logic [7:0] CMD_READ_EEPROM = 8'h03;
   // memory geometry
   localparam int FLASH_WORDS = 8192;
   localparam int FLASH_PAGE_LSB = 6;
   localparam int FLASH_PAGE_MSB = 12;
   localparam int EE_BYTES = 512;
   localparam int EE_PAGE_LSB = 2;
   localparam int EE_PAGE_MSB = 8;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] LOCK_RESET = 8'hFF;
   localparam logic [7:0] FUSE_LO_RESET = 8'hFF;
   localparam logic [7:0] FUSE_HI_RESET = 8'hFF;
   // arbitrary neutral signature and calibration values
   localparam logic [7:0] SIG_BYTE0 = 8'hA5;
   localparam logic [7:0] SIG_BYTE1 = 8'h5A;
   localparam logic [7:0] SIG_BYTE2 = 8'h3C;
   localparam logic [7:0] CAL_BYTE = 8'h80;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int ENTRY_STABLE_NS = 100;
   localparam int ENTRY_STABLE_CYC = (ENTRY_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ENTRY_TOGGLES = 6;
   localparam int PROG_CYC = 8;
   localparam logic [3:0] ENTRY_PATTERN = 4'h0;

   typedef enum {ST_OFF, ST_ARM, ST_SETTLE, ST_READY, ST_PROG, ST_ERASE_FL, ST_ERASE_EE,
      ST_ERASE_LOCK} ppp_state_type;

   typedef struct packed {
      logic load_clock;
      logic page_latch_strobe;
      logic action_code_hi;
      logic action_code_lo;
      logic half_select;
      logic byte_select2;
      logic write_n;
      logic out_enable_n;
      logic prog_voltage;
      logic [7:0] data_in;
   } ppp_pins_type;

   typedef struct packed {
      ppp_state_type st;
      logic [3:0] toggles;
      logic [7:0] cnt;
      logic [13:0] idx;
      logic [7:0] cmd;
      logic [7:0] addr_hi;
      logic [7:0] addr_lo;
      logic [7:0] data_lo;
      logic [7:0] data_hi;
      logic [7:0] lock;
      logic [7:0] fuse_lo;
      logic [7:0] fuse_hi;
      logic [7:0] dout;
      logic dout_en;
      logic ready_busy;
      logic in_prog;
      logic ld_clk_d;
      logic wr_d;
      logic latch_d;
   } ppp_state_struct_type;
endpackage

// >>> testbench/ppp_programmer.sv
`timescale 1ns/100ps
// released bus shows the inverse of the last drive, not a stale value
module ppp_programmer (
   input wire logic core_clk,
   input wire logic ready_busy,
   input wire logic data_oe,
   input wire logic [7:0] data_out,
   output ppp_pkg::ppp_pins_type pins,
   output logic [7:0] bus
);
   logic drv_en;
   assign bus = data_oe ? data_out : (drv_en ? pins.data_in : ~pins.data_in);
   task automatic idle();
      pins = '{write_n: 1'b1, out_enable_n: 1'b1, default: '0};
      drv_en = 1'b1;
   endtask
   // every level held 4 cycles, above the 3 the pin sync needs
   task automatic hold();
      repeat (4) @(posedge core_clk);
      #1;
   endtask
   task automatic pulse_ld();
      pins.load_clock = 1'b1;
      hold();
      pins.load_clock = 1'b0;
      hold();
   endtask
   task automatic load(input logic [1:0] act, input logic hs, input logic [7:0] d);
      drv_en = 1'b1;
      {pins.action_code_hi, pins.action_code_lo} = act;
      pins.half_select = hs;
      pins.data_in = d;
      hold();
      pulse_ld();
   endtask
   task automatic enter(input logic glitch);
      idle();
      hold();
      repeat (6) pulse_ld();
      hold();
      pins.prog_voltage = 1'b1;
      hold();
      pins.half_select = glitch;
      repeat (4) hold();
   endtask
   task automatic latch();
      pins.page_latch_strobe = 1'b1;
      hold();
      pins.page_latch_strobe = 1'b0;
      hold();
   endtask
   task automatic wr(output logic busy_seen);
      pins.write_n = 1'b0;
      hold();
      busy_seen = !ready_busy;
      pins.write_n = 1'b1;
      repeat (9000) if (!ready_busy) @(posedge core_clk);
      hold();
   endtask
   task automatic rd(input logic hs, input logic bs2, output logic [7:0] v);
      pins.half_select = hs;
      pins.byte_select2 = bs2;
      drv_en = 1'b0;
      pins.out_enable_n = 1'b0;
      hold();
      v = bus;
      pins.out_enable_n = 1'b1;
      // bus stays released until the next load drives it
      hold();
   endtask
   initial idle();
endmodule // ppp_programmer

// >>> testbench/ppp_sva.sv
`timescale 1ns/100ps
module ppp_sva (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic load_clock,
   input wire logic page_latch_strobe,
   input wire logic action_code_hi,
   input wire logic action_code_lo,
   input wire logic half_select,
   input wire logic byte_select2,
   input wire logic write_n,
   input wire logic out_enable_n,
   input wire logic prog_voltage,
   input wire logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic ready_busy,
   input wire logic prog_mode
);
   logic [7:0] cmd_r;
   logic [15:0] busy_r;
   logic ld_prev_r;
   // command shadow, so the erase check needs no look inside the block
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cmd_r <= 8'h00;
         busy_r <= 16'h0000;
         ld_prev_r <= 1'b0;
      end else begin
         ld_prev_r <= load_clock;
         if (load_clock && !ld_prev_r && action_code_hi && !action_code_lo && prog_mode && ready_busy)
            cmd_r <= data_in;
         busy_r <= ready_busy ? 16'h0000 : busy_r + 16'h0001;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   erase_start_a: assert property ($fell(write_n) && ready_busy && prog_mode && cmd_r == 8'h80 |-> ##3 !ready_busy)
      else $error("erase did not go busy");
   busy_length_a: assert property ($rose(ready_busy) |-> $past(busy_r) inside {[16'h0007:16'h000A], [16'h1FFE:16'h2206]})
      else $error("busy time out of range");
   busy_cause_a: assert property ($fell(ready_busy) |-> !$past(write_n, 3) || !$past(write_n, 4))
      else $error("busy without write strobe");
   oe_drive_a: assert property (prog_mode && ready_busy && $fell(out_enable_n) |-> ##3 data_oe)
      else $error("bus not driven on read");
   oe_release_a: assert property (out_enable_n [*4] |=> !data_oe)
      else $error("bus still driven");
   oe_cause_a: assert property (data_oe |-> !$past(out_enable_n, 3))
      else $error("bus driven without enable");
   mode_exit_a: assert property (!prog_voltage [*4] |=> !prog_mode)
      else $error("mode without voltage");
   mode_entry_a: assert property ($rose(prog_mode) |-> $past(prog_voltage, 10)
      && !$past(page_latch_strobe | action_code_hi | action_code_lo | half_select, 4))
      else $error("mode entered without pattern");
   cover property ($rose(prog_mode));
   cover property ($fell(ready_busy));
   cover property ($rose(data_oe));
endmodule // ppp_sva

bind ppp_parallel_port ppp_sva chk (.core_clk(core_clk), .arst_n(arst_n), .load_clock(load_clock),
   .page_latch_strobe(page_latch_strobe), .action_code_hi(action_code_hi), .action_code_lo(action_code_lo),
   .half_select(half_select), .byte_select2(byte_select2), .write_n(write_n), .out_enable_n(out_enable_n),
   .prog_voltage(prog_voltage), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
   .ready_busy(ready_busy), .prog_mode(prog_mode));

// >>> testbench/tb.sv
`timescale 1ns/100ps
module tb;
   logic core_clk, arst_n, data_oe, ready_busy, prog_mode, b;
   logic [7:0] bus, data_out, v;
   ppp_pkg::ppp_pins_type pins;
   int num_errors, checks, cycles;
   ppp_programmer prog (.core_clk(core_clk), .ready_busy(ready_busy), .data_oe(data_oe), .data_out(data_out),
      .pins(pins), .bus(bus));
   ppp_parallel_port dut (.core_clk(core_clk), .arst_n(arst_n), .load_clock(pins.load_clock),
      .page_latch_strobe(pins.page_latch_strobe), .action_code_hi(pins.action_code_hi),
      .action_code_lo(pins.action_code_lo), .half_select(pins.half_select), .byte_select2(pins.byte_select2),
      .write_n(pins.write_n), .out_enable_n(pins.out_enable_n), .prog_voltage(pins.prog_voltage), .data_in(bus),
      .data_out(data_out), .data_oe(data_oe), .ready_busy(ready_busy), .prog_mode(prog_mode));
   task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] c);
      prog.load(ppp_pkg::ACT_LOAD_CMD, 1'b0, c);
   endtask
   task automatic adr(input logic hs, input logic [7:0] a);
      prog.load(ppp_pkg::ACT_LOAD_ADDR, hs, a);
   endtask
   task automatic dat(input logic hs, input logic [7:0] d);
      prog.load(ppp_pkg::ACT_LOAD_DATA, hs, d);
   endtask
   task automatic rdc(input string n, input logic hs, input logic bs2, input logic [7:0] e);
      prog.rd(hs, bs2, v);
      chk(n, v, e);
   endtask
   task automatic wrc();
      prog.wr(b);
      chk("busy", {7'h00, b}, 8'h01);
   endtask
   task automatic t_entry();
      prog.enter(1'b1);
      chk("mode glitch", {7'h00, prog_mode}, 8'h00);
      prog.enter(1'b0);
      chk("mode", {7'h00, prog_mode}, 8'h01);
      chk("ready", {7'h00, ready_busy}, 8'h01);
      $display("entry done");
   endtask
   task automatic t_sig();
      cmd(ppp_pkg::CMD_READ_SIG);
      prog.load(ppp_pkg::ACT_IDLE, 1'b0, ppp_pkg::CMD_READ_FLASH);
      adr(1'b1, 8'h00);
      adr(1'b0, 8'h00);
      rdc("cal", 1'b1, 1'b0, ppp_pkg::CAL_BYTE);
      for (int i = 0; i < 3; i++) begin
         adr(1'b0, 8'(i));
         rdc("sig", 1'b0, 1'b0, i == 0 ? ppp_pkg::SIG_BYTE0 : i == 1 ? ppp_pkg::SIG_BYTE1 : ppp_pkg::SIG_BYTE2);
      end
      chk("oe idle", {7'h00, data_oe}, 8'h00);
      $display("signature done");
   endtask
   task automatic t_erase();
      cmd(ppp_pkg::CMD_WRITE_LOCK);
      dat(1'b0, 8'hFC);
      wrc();
      cmd(ppp_pkg::CMD_READ_FUSE_LOCK);
      rdc("lock", 1'b0, 1'b1, 8'hFC);
      cmd(ppp_pkg::CMD_CHIP_ERASE);
      wrc();
      cmd(ppp_pkg::CMD_READ_FUSE_LOCK);
      rdc("lock erased", 1'b0, 1'b1, ppp_pkg::LOCK_RESET);
      cmd(ppp_pkg::CMD_READ_FLASH);
      adr(1'b1, 8'h10);
      adr(1'b0, 8'h41);
      rdc("flash erased", 1'b1, 1'b0, ppp_pkg::ERASED_BYTE);
      $display("erase done");
   endtask
   task automatic t_write();
      cmd(ppp_pkg::CMD_WRITE_FLASH);
      adr(1'b1, 8'h10);
      adr(1'b0, 8'h41);
      dat(1'b0, 8'h34);
      dat(1'b1, 8'h12);
      prog.latch();
      wrc();
      cmd(ppp_pkg::CMD_READ_FLASH);
      rdc("flash lo", 1'b0, 1'b0, 8'h34);
      rdc("flash hi", 1'b1, 1'b0, 8'h12);
      adr(1'b0, 8'h40);
      rdc("unlatched word", 1'b0, 1'b0, ppp_pkg::ERASED_BYTE);
      adr(1'b0, 8'h01);
      rdc("other page", 1'b0, 1'b0, ppp_pkg::ERASED_BYTE);
      cmd(ppp_pkg::CMD_WRITE_EEPROM);
      adr(1'b1, 8'h01);
      adr(1'b0, 8'h05);
      dat(1'b0, 8'h5C);
      prog.latch();
      wrc();
      cmd(ppp_pkg::CMD_READ_EEPROM);
      rdc("eeprom", 1'b0, 1'b0, 8'h5C);
      adr(1'b0, 8'h09);
      rdc("eeprom page", 1'b0, 1'b0, ppp_pkg::ERASED_BYTE);
      $display("write done");
   endtask
   task automatic t_keep();
      cmd(ppp_pkg::CMD_WRITE_FUSE);
      prog.load(ppp_pkg::ACT_IDLE, 1'b1, 8'hF7);
      wrc();
      cmd(ppp_pkg::CMD_CHIP_ERASE);
      wrc();
      cmd(ppp_pkg::CMD_READ_FUSE_LOCK);
      rdc("fuse hi", 1'b1, 1'b0, 8'hF7);
      cmd(ppp_pkg::CMD_READ_EEPROM);
      adr(1'b0, 8'h05);
      rdc("eeprom kept", 1'b0, 1'b0, 8'h5C);
      $display("keep done");
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // two erases of about 8.7k and 8.2k cycles dominate the run
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         test_done();
      end
   end
   initial begin
      arst_n = 1'b0;
      num_errors = 0;
      checks = 0;
      cycles = 0;
      repeat (8) @(posedge core_clk);
      #1;
      arst_n = 1'b1;
      t_entry();
      t_sig();
      t_erase();
      t_write();
      t_keep();
      test_done();
   end
endmodule // tb

// >>> verilog/ppp_parallel_port.sv
`timescale 1ns/100ps
module ppp_parallel_port (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic load_clock,
   input wire logic page_latch_strobe,
   input wire logic action_code_hi,
   input wire logic action_code_lo,
   input wire logic half_select,
   input wire logic byte_select2,
   input wire logic write_n,
   input wire logic out_enable_n,
   input wire logic prog_voltage,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic ready_busy,
   output logic prog_mode
);
   ppp_pkg::ppp_pins_type p1_r, p2_r, p;
   ppp_pkg::ppp_state_struct_type s_r, s_nxt;
   logic [15:0] flash_mem [ppp_pkg::FLASH_WORDS];
   logic [7:0] ee_mem [ppp_pkg::EE_BYTES];
   logic [15:0] page_buf [1 << ppp_pkg::FLASH_PAGE_LSB];
   logic fl_we, ee_we, pb_we, fl_clr, ee_clr;
   logic [12:0] fl_addr;
   logic [8:0] ee_addr;
   logic keep_eeprom_fuse;

   // pins are asynchronous to core_clk: two stages before use
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         // idle pin levels, so no false strobe edge follows reset
         p1_r <= '{write_n: 1'b1, out_enable_n: 1'b1, default: '0};
         p2_r <= '{write_n: 1'b1, out_enable_n: 1'b1, default: '0};
      end else begin
         p1_r <= {load_clock, page_latch_strobe, action_code_hi, action_code_lo, half_select,
            byte_select2, write_n, out_enable_n, prog_voltage, data_in};
         p2_r <= p1_r;
      end
   end
   assign p = p2_r;

   assign fl_addr = {s_r.addr_hi[4:0], s_r.addr_lo};
   assign ee_addr = {s_r.addr_hi[0], s_r.addr_lo};
   assign keep_eeprom_fuse = ~s_r.fuse_hi[3];

   function automatic logic is_write_cmd(input logic [7:0] c);
      is_write_cmd = (c == ppp_pkg::CMD_WRITE_FUSE) || (c == ppp_pkg::CMD_WRITE_LOCK) ||
         (c == ppp_pkg::CMD_WRITE_FLASH) || (c == ppp_pkg::CMD_WRITE_EEPROM);
   endfunction

   always_comb begin
      logic ld_rise, wr_fall, latch_rise;
      ld_rise = p.load_clock & ~s_r.ld_clk_d;
      wr_fall = ~p.write_n & s_r.wr_d;
      latch_rise = p.page_latch_strobe & ~s_r.latch_d;
      s_nxt = s_r;
      s_nxt.ld_clk_d = p.load_clock;
      s_nxt.wr_d = p.write_n;
      s_nxt.latch_d = p.page_latch_strobe;
      s_nxt.dout_en = 1'b0;
      fl_we = 1'b0;
      ee_we = 1'b0;
      pb_we = 1'b0;
      fl_clr = 1'b0;
      ee_clr = 1'b0;
      case (s_r.st)
         ppp_pkg::ST_OFF: begin
            s_nxt.in_prog = 1'b0;
            s_nxt.ready_busy = 1'b1;
            if (p.prog_voltage) begin
               s_nxt.toggles = '0;
            end else if (ld_rise && s_r.toggles < 4'(ppp_pkg::ENTRY_TOGGLES)) begin
               s_nxt.toggles = s_r.toggles + 4'h1;
            end
            if (!p.prog_voltage && s_r.toggles >= 4'(ppp_pkg::ENTRY_TOGGLES)) begin
               s_nxt.st = ppp_pkg::ST_ARM;
            end
         end
         ppp_pkg::ST_ARM: begin
            if (p.prog_voltage) begin
               s_nxt.cnt = '0;
               s_nxt.st = ({p.page_latch_strobe, p.action_code_hi, p.action_code_lo, p.half_select} ==
                  ppp_pkg::ENTRY_PATTERN) ? ppp_pkg::ST_SETTLE : ppp_pkg::ST_OFF;
            end
         end
         ppp_pkg::ST_SETTLE: begin
            // any activity on entry pins aborts entry
            if (!p.prog_voltage || {p.page_latch_strobe, p.action_code_hi, p.action_code_lo,
                  p.half_select} != ppp_pkg::ENTRY_PATTERN) begin
               s_nxt.st = ppp_pkg::ST_OFF;
               s_nxt.toggles = '0;
            end else if (s_r.cnt >= 8'(ppp_pkg::ENTRY_STABLE_CYC)) begin
               s_nxt.st = ppp_pkg::ST_READY;
               s_nxt.in_prog = 1'b1;
            end else begin
               s_nxt.cnt = s_r.cnt + 8'h01;
            end
         end
         ppp_pkg::ST_READY: begin
            s_nxt.ready_busy = 1'b1;
            if (ld_rise) begin
               case ({p.action_code_hi, p.action_code_lo})
                  ppp_pkg::ACT_LOAD_ADDR: begin
                     // high byte retained until reloaded
                     if (p.half_select) s_nxt.addr_hi = p.data_in;
                     else s_nxt.addr_lo = p.data_in;
                  end
                  ppp_pkg::ACT_LOAD_DATA: begin
                     if (p.half_select) s_nxt.data_hi = p.data_in;
                     else s_nxt.data_lo = p.data_in;
                  end
                  ppp_pkg::ACT_LOAD_CMD: s_nxt.cmd = p.data_in;
                  default: ;
               endcase
            end
            if (latch_rise && s_r.cmd == ppp_pkg::CMD_WRITE_FLASH) begin
               pb_we = 1'b1;
            end
            if (wr_fall) begin
               if (s_r.cmd == ppp_pkg::CMD_CHIP_ERASE) begin
                  s_nxt.st = ppp_pkg::ST_ERASE_FL;
                  s_nxt.idx = '0;
                  s_nxt.ready_busy = 1'b0;
               end else if (is_write_cmd(s_r.cmd)) begin
                  s_nxt.st = ppp_pkg::ST_PROG;
                  s_nxt.cnt = '0;
                  s_nxt.ready_busy = 1'b0;
                  if (s_r.cmd == ppp_pkg::CMD_WRITE_FUSE) begin
                     if (p.half_select) s_nxt.fuse_hi = p.data_in;
                     else s_nxt.fuse_lo = p.data_in;
                  end
                  // lock bits can only be programmed toward zero
                  if (s_r.cmd == ppp_pkg::CMD_WRITE_LOCK) s_nxt.lock = s_r.lock & s_r.data_lo;
                  if (s_r.cmd == ppp_pkg::CMD_WRITE_FLASH) fl_we = 1'b1;
                  if (s_r.cmd == ppp_pkg::CMD_WRITE_EEPROM) ee_we = 1'b1;
               end
            end
            if (!p.out_enable_n) begin
               s_nxt.dout_en = 1'b1;
               case (s_r.cmd)
                  ppp_pkg::CMD_READ_SIG: begin
                     if (p.half_select) s_nxt.dout = ppp_pkg::CAL_BYTE;
                     else if (s_r.addr_lo == 8'h00) s_nxt.dout = ppp_pkg::SIG_BYTE0;
                     else if (s_r.addr_lo == 8'h01) s_nxt.dout = ppp_pkg::SIG_BYTE1;
                     else s_nxt.dout = ppp_pkg::SIG_BYTE2;
                  end
                  ppp_pkg::CMD_READ_FUSE_LOCK: begin
                     if (p.byte_select2) s_nxt.dout = s_r.lock;
                     else if (p.half_select) s_nxt.dout = s_r.fuse_hi;
                     else s_nxt.dout = s_r.fuse_lo;
                  end
                  ppp_pkg::CMD_READ_FLASH: begin
                     s_nxt.dout = p.half_select ? flash_mem[fl_addr][15:8] : flash_mem[fl_addr][7:0];
                  end
                  ppp_pkg::CMD_READ_EEPROM: s_nxt.dout = ee_mem[ee_addr];
                  default: s_nxt.dout = '0;
               endcase
            end
         end
         ppp_pkg::ST_PROG: begin
            if (s_r.cnt >= 8'(ppp_pkg::PROG_CYC)) begin
               s_nxt.st = ppp_pkg::ST_READY;
               s_nxt.ready_busy = 1'b1;
            end else begin
               s_nxt.cnt = s_r.cnt + 8'h01;
            end
         end
         ppp_pkg::ST_ERASE_FL: begin
            fl_clr = 1'b1;
            s_nxt.idx = s_r.idx + 14'h0001;
            if (s_r.idx == 14'(ppp_pkg::FLASH_WORDS - 1)) begin
               s_nxt.idx = '0;
               s_nxt.st = keep_eeprom_fuse ? ppp_pkg::ST_ERASE_LOCK : ppp_pkg::ST_ERASE_EE;
            end
         end
         ppp_pkg::ST_ERASE_EE: begin
            ee_clr = 1'b1;
            s_nxt.idx = s_r.idx + 14'h0001;
            if (s_r.idx == 14'(ppp_pkg::EE_BYTES - 1)) s_nxt.st = ppp_pkg::ST_ERASE_LOCK;
         end
         ppp_pkg::ST_ERASE_LOCK: begin
            // only reached after whole program memory is blank; fuses untouched
            s_nxt.lock = ppp_pkg::LOCK_RESET;
            s_nxt.st = ppp_pkg::ST_READY;
            s_nxt.ready_busy = 1'b1;
         end
         default: s_nxt.st = ppp_pkg::ST_OFF;
      endcase
      // dropping high voltage leaves programming mode
      if (s_r.st >= ppp_pkg::ST_READY && !p.prog_voltage) begin
         s_nxt.st = ppp_pkg::ST_OFF;
         s_nxt.toggles = '0;
         s_nxt.dout_en = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '{st: ppp_pkg::ST_OFF, ready_busy: 1'b1, lock: ppp_pkg::LOCK_RESET,
            fuse_lo: ppp_pkg::FUSE_LO_RESET, fuse_hi: ppp_pkg::FUSE_HI_RESET, ld_clk_d: 1'b0,
            wr_d: 1'b1, latch_d: 1'b0, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // memory arrays carry no reset; erase is done by the sequencer
   always_ff @(posedge core_clk) begin
      if (fl_clr) begin
         flash_mem[s_r.idx[12:0]] <= {ppp_pkg::ERASED_BYTE, ppp_pkg::ERASED_BYTE};
         // blank buffer, so words never latched program as erased
         page_buf[s_r.idx[5:0]] <= {ppp_pkg::ERASED_BYTE, ppp_pkg::ERASED_BYTE};
      end else if (fl_we) begin
         for (int i = 0; i < (1 << ppp_pkg::FLASH_PAGE_LSB); i++) begin
            flash_mem[{fl_addr[ppp_pkg::FLASH_PAGE_MSB:ppp_pkg::FLASH_PAGE_LSB], 6'(i)}] <= page_buf[i];
            page_buf[i] <= {ppp_pkg::ERASED_BYTE, ppp_pkg::ERASED_BYTE};
         end
      end
      // placed last so a latch in the write cycle still lands
      if (pb_we) page_buf[s_r.addr_lo[5:0]] <= {s_r.data_hi, s_r.data_lo};
      if (ee_clr) ee_mem[s_r.idx[8:0]] <= ppp_pkg::ERASED_BYTE;
      else if (ee_we) ee_mem[ee_addr] <= s_r.data_lo;
   end

   assign data_out = s_r.dout;
   assign data_oe = s_r.dout_en;
   assign ready_busy = s_r.ready_busy;
   assign prog_mode = s_r.in_prog;
endmodule // ppp_parallel_port
